// ===== hw/gpio_ports_8_to_10.sv
// gpio block for port eight (7 bits), port nine (5 bits), port ten (7 bits)
// assumes pins asynchronous to sys_clk_i, peripherals on sys_clk_i, chip reset on srst_i
//
// Behaviour
// - any reset clears direction, select, data
// - direction zero reads live pin
// - output, no select reads data register
// - port eight secondary read returns peripheral outputs
// - read-modify-write uses read selection, writes data
// - port nine has bits 0-3 and 7
// - direction one, no select drives data onto pin
// - peripheral output only with direction and select
// - input with select enables pull-up
// - port nine bits 0-3 secondary drive low
// - port nine secondary read zero, bit7 hold-ack
// - absent bits read zero
// - port ten has bits 0-5 and 7
// - port ten bits 1,3,4,5,7 secondary low
// - port ten secondary read clock bit0, data bit2
// - port eight seven bits, direction, pull-up
// - port eight bit0 secondary drives low
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
module gpio_ports_8_to_10
  import gpio_ports_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] p8_pin_i,
  output logic      [7:0] p8_pin_o,
  output logic      [7:0] p8_pin_oe_o,
  output logic      [7:0] p8_pull_o,
  input  wire logic [7:0] p9_pin_i,
  output logic      [7:0] p9_pin_o,
  output logic      [7:0] p9_pin_oe_o,
  output logic      [7:0] p9_pull_o,
  input  wire logic [7:0] p10_pin_i,
  output logic      [7:0] p10_pin_o,
  output logic      [7:0] p10_pin_oe_o,
  output logic      [7:0] p10_pull_o,
  input  wire logic       serial1_transmit_data_i,
  input  wire logic       serial1_receive_clock_i,
  input  wire logic       serial1_transmit_clock_i,
  input  wire logic       timer_four_output_i,
  input  wire logic       pwm_channel_two_output_i,
  input  wire logic       pwm_channel_three_output_i,
  input  wire logic       bus_hold_acknowledge_i,
  input  wire logic       serial3_clock_i,
  input  wire logic       serial3_data_out_i,
  output logic            serial1_receive_data_o,
  output logic            serial1_receive_clock_o,
  output logic            serial1_transmit_clock_o,
  output logic            external_irq_four_o,
  output logic            external_irq_five_o,
  output logic            serial3_clock_o,
  output logic            serial3_data_in_o,
  output logic            timer_five_event_input_o
);
  logic [7:0] p8_meta_q, p8_sync_q, p9_meta_q, p9_sync_q, p10_meta_q, p10_sync_q;
  logic [7:0] p8_alt, p9_alt, p10_alt;
  logic [7:0] p8_data, p8_dir, p8_sel, p8_rd, p8_o, p8_oe, p8_pu;
  logic [7:0] p9_data, p9_dir, p9_sel, p9_rd, p9_o, p9_oe, p9_pu;
  logic [7:0] p10_data, p10_dir, p10_sel, p10_rd, p10_o, p10_oe, p10_pu;
  logic [7:0] rdata_d;

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target);
    wr_hit = (a == target);
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      p8_meta_q  <= 8'h00;
      p8_sync_q  <= 8'h00;
      p9_meta_q  <= 8'h00;
      p9_sync_q  <= 8'h00;
      p10_meta_q <= 8'h00;
      p10_sync_q <= 8'h00;
    end else begin
      p8_meta_q  <= p8_pin_i;
      p8_sync_q  <= p8_meta_q;
      p9_meta_q  <= p9_pin_i;
      p9_sync_q  <= p9_meta_q;
      p10_meta_q <= p10_pin_i;
      p10_sync_q <= p10_meta_q;
    end
  end

  // peripheral outputs placed at their pin positions
  assign p8_alt  = {pwm_channel_three_output_i, pwm_channel_two_output_i, 1'b0,
                    timer_four_output_i, serial1_transmit_clock_i,
                    serial1_receive_clock_i, serial1_transmit_data_i, 1'b0};
  assign p9_alt  = {bus_hold_acknowledge_i, 7'h00};
  assign p10_alt = {5'h00, serial3_data_out_i, 1'b0, serial3_clock_i};

  gpio_port_bank #(.IMPL_MASK(P8_IMPL_MASK), .FIXED_LOW(P8_FIXED_LOW)) u_p8 (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .wr_data_i (wr_i && wr_hit(addr_i, ADDR_P8_DATA)),
    .wr_dir_i  (wr_i && wr_hit(addr_i, ADDR_P8_DIR)),
    .wr_alt_i  (wr_i && wr_hit(addr_i, ADDR_P8_ALT)),
    .wdata_i   (wdata_i),
    .pin_sync_i(p8_sync_q),
    .alt_out_i (p8_alt),
    .alt_read_i(p8_alt),
    .data_q_o  (p8_data),
    .dir_q_o   (p8_dir),
    .alt_q_o   (p8_sel),
    .read_o    (p8_rd),
    .pin_o_d   (p8_o),
    .pin_oe_d  (p8_oe),
    .pull_d    (p8_pu)
  );

  gpio_port_bank #(.IMPL_MASK(P9_IMPL_MASK), .FIXED_LOW(P9_FIXED_LOW)) u_p9 (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .wr_data_i (wr_i && wr_hit(addr_i, ADDR_P9_DATA)),
    .wr_dir_i  (wr_i && wr_hit(addr_i, ADDR_P9_DIR)),
    .wr_alt_i  (wr_i && wr_hit(addr_i, ADDR_P9_ALT)),
    .wdata_i   (wdata_i),
    .pin_sync_i(p9_sync_q),
    .alt_out_i (p9_alt),
    .alt_read_i(p9_alt),
    .data_q_o  (p9_data),
    .dir_q_o   (p9_dir),
    .alt_q_o   (p9_sel),
    .read_o    (p9_rd),
    .pin_o_d   (p9_o),
    .pin_oe_d  (p9_oe),
    .pull_d    (p9_pu)
  );

  gpio_port_bank #(.IMPL_MASK(P10_IMPL_MASK), .FIXED_LOW(P10_FIXED_LOW)) u_p10 (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .wr_data_i (wr_i && wr_hit(addr_i, ADDR_P10_DATA)),
    .wr_dir_i  (wr_i && wr_hit(addr_i, ADDR_P10_DIR)),
    .wr_alt_i  (wr_i && wr_hit(addr_i, ADDR_P10_ALT)),
    .wdata_i   (wdata_i),
    .pin_sync_i(p10_sync_q),
    .alt_out_i (p10_alt),
    .alt_read_i(p10_alt),
    .data_q_o  (p10_data),
    .dir_q_o   (p10_dir),
    .alt_q_o   (p10_sel),
    .read_o    (p10_rd),
    .pin_o_d   (p10_o),
    .pin_oe_d  (p10_oe),
    .pull_d    (p10_pu)
  );

  // read mux: data address returns the selected view, unmapped reads zero
  always_comb begin
    case (addr_i)
      ADDR_P8_DATA:  rdata_d = p8_rd;
      ADDR_P8_DIR:   rdata_d = p8_dir;
      ADDR_P8_ALT:   rdata_d = p8_sel;
      ADDR_P9_DATA:  rdata_d = p9_rd;
      ADDR_P9_DIR:   rdata_d = p9_dir;
      ADDR_P9_ALT:   rdata_d = p9_sel;
      ADDR_P10_DATA: rdata_d = p10_rd;
      ADDR_P10_DIR:  rdata_d = p10_dir;
      ADDR_P10_ALT:  rdata_d = p10_sel;
      default:       rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o                  <= 8'h00;
      p8_pin_o                 <= 8'h00;
      p8_pin_oe_o              <= 8'h00;
      p8_pull_o                <= 8'h00;
      p9_pin_o                 <= 8'h00;
      p9_pin_oe_o              <= 8'h00;
      p9_pull_o                <= 8'h00;
      p10_pin_o                <= 8'h00;
      p10_pin_oe_o             <= 8'h00;
      p10_pull_o               <= 8'h00;
      serial1_receive_data_o   <= 1'b0;
      serial1_receive_clock_o  <= 1'b0;
      serial1_transmit_clock_o <= 1'b0;
      external_irq_four_o      <= 1'b0;
      external_irq_five_o      <= 1'b0;
      serial3_clock_o          <= 1'b0;
      serial3_data_in_o        <= 1'b0;
      timer_five_event_input_o <= 1'b0;
    end else begin
      rdata_o                  <= rd_i ? rdata_d : 8'h00;
      p8_pin_o                 <= p8_o;
      p8_pin_oe_o              <= p8_oe;
      p8_pull_o                <= p8_pu;
      p9_pin_o                 <= p9_o;
      p9_pin_oe_o              <= p9_oe;
      p9_pull_o                <= p9_pu;
      p10_pin_o                <= p10_o;
      p10_pin_oe_o             <= p10_oe;
      p10_pull_o               <= p10_pu;
      // peripheral inputs share the port input path
      serial1_receive_data_o   <= p8_sync_q[0];
      serial1_receive_clock_o  <= p8_sync_q[2];
      serial1_transmit_clock_o <= p8_sync_q[3];
      external_irq_four_o      <= p9_sync_q[0];
      external_irq_five_o      <= p9_sync_q[1];
      serial3_clock_o          <= p10_sync_q[0];
      serial3_data_in_o        <= p10_sync_q[1];
      timer_five_event_input_o <= p10_sync_q[7];
    end
  end

  reset_clear_a: assert property (@(posedge sys_clk_i)
    srst_i |=> (p8_pin_oe_o == 8'h00 && p9_dir == 8'h00 && p10_sel == 8'h00))
    else $error("reset did not clear port state");
  input_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P9_DATA && p9_dir == 8'h00)
      |=> rdata_o == ($past(p9_sync_q) & P9_IMPL_MASK))
    else $error("input read not pin level");
  data_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P8_DATA && p8_dir[1] && !p8_sel[1])
      |=> rdata_o[1] == $past(p8_data[1]))
    else $error("output read not data register");
  p8_alt_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P8_DATA && p8_dir[1] && p8_sel[1])
      |=> rdata_o[1] == $past(serial1_transmit_data_i))
    else $error("port eight alternate read wrong");
  drive_data_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (p10_dir[6] == 1'b0 && p10_dir[2] && !p10_sel[2])
      |=> p10_pin_oe_o[2] && p10_pin_o[2] == $past(p10_data[2]))
    else $error("output pin not data");
  pull_up_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!p8_dir[4] && p8_sel[4]) |=> p8_pull_o[4])
    else $error("pull-up missing");
  p9_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (p9_dir[0] && p9_sel[0]) |=> (p9_pin_oe_o[0] && !p9_pin_o[0]))
    else $error("port nine bit0 not low");
  absent_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P9_DATA)
      |=> (rdata_o & ~P9_IMPL_MASK) == 8'h00 && p9_pin_oe_o[6:4] == 3'h0)
    else $error("absent bit active");
  p10_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (p10_dir[7] && p10_sel[7]) |=> !p10_pin_o[7])
    else $error("port ten bit7 not low");
  p10_alt_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P10_DATA && p10_dir[0] && p10_sel[0])
      |=> rdata_o[0] == $past(serial3_clock_i))
    else $error("port ten clock read wrong");

  // port eight pin drive and read-back
  p8_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (p8_dir[0] && p8_sel[0]) |=> (p8_pin_oe_o[0] && !p8_pin_o[0]))
    else $error("port eight bit0 not low");
  p8_zero_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P8_DATA && p8_dir[0] && p8_sel[0]) |=> !rdata_o[0])
    else $error("port eight bit0 read not zero");
  p8_alt_drive_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (p8_dir[6] && p8_sel[6]) |=> p8_pin_o[6] == $past(pwm_channel_two_output_i))
    else $error("port eight pwm pin wrong");
  port_drive_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !p8_sel[1] |=> p8_pin_o[1] == $past(p8_dir[1] && p8_data[1]))
    else $error("peripheral drives without select");
  p8_absent_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ((p8_pin_oe_o | p8_pull_o) & ~P8_IMPL_MASK) == 8'h00)
    else $error("port eight absent bit active");

  // port nine read-back, interrupt input and absent bits
  p9_hold_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P9_DATA && p9_dir[7] && p9_sel[7])
      |=> rdata_o[7] == $past(bus_hold_acknowledge_i))
    else $error("port nine hold read wrong");
  p9_zero_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P9_DATA)
      |=> (rdata_o[3:0] & $past(p9_dir[3:0] & p9_sel[3:0])) == 4'h0)
    else $error("port nine low bits read not zero");
  irq_input_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> external_irq_five_o == $past(p9_sync_q[1]))
    else $error("interrupt input not pin path");
  p9_absent_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ((p9_pin_oe_o | p9_pull_o) & ~P9_IMPL_MASK) == 8'h00)
    else $error("port nine absent bit active");

  // port ten read-back, pull-up and absent bits
  p10_zero_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P10_DATA)
      |=> (rdata_o & $past(p10_dir & p10_sel) & P10_FIXED_LOW) == 8'h00)
    else $error("port ten secondary read not zero");
  p10_data_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (rd_i && addr_i == ADDR_P10_DATA && p10_dir[2] && p10_sel[2])
      |=> rdata_o[2] == $past(serial3_data_out_i))
    else $error("port ten data read wrong");
  p10_pull_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!p10_dir[0] && p10_sel[0]) |=> p10_pull_o[0])
    else $error("port ten pull-up missing");
  p10_absent_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ((p10_pin_oe_o | p10_pull_o) & ~P10_IMPL_MASK) == 8'h00)
    else $error("port ten absent bit active");

  cov_alt_out_c: cover property (@(posedge sys_clk_i) p8_pin_oe_o[6] && p8_pin_o[6]);
  cov_pull_c: cover property (@(posedge sys_clk_i) p10_pull_o[0]);
  cov_rd_after_wr_c: cover property (@(posedge sys_clk_i) wr_i ##1 rd_i);
  cov_hold_read_c: cover property (@(posedge sys_clk_i)
    rd_i && addr_i == ADDR_P9_DATA && p9_dir[7] && p9_sel[7]);
  cov_fixed_low_c: cover property (@(posedge sys_clk_i)
    p10_pin_oe_o[7] && !p10_pin_o[7] && p10_data[7]);
endmodule // gpio_ports_8_to_10

// ===== hw/gpio_ports_pkg.sv
// package for the port eight/nine/ten gpio block
// assumes an 8-bit register port with word index addresses
package gpio_ports_pkg;
  localparam logic [3:0] ADDR_P8_DATA = 4'h0;
  localparam logic [3:0] ADDR_P8_DIR  = 4'h1;
  localparam logic [3:0] ADDR_P8_ALT  = 4'h2;
  localparam logic [3:0] ADDR_P9_DATA = 4'h3;
  localparam logic [3:0] ADDR_P9_DIR  = 4'h4;
  localparam logic [3:0] ADDR_P9_ALT  = 4'h5;
  localparam logic [3:0] ADDR_P10_DATA = 4'h6;
  localparam logic [3:0] ADDR_P10_DIR  = 4'h7;
  localparam logic [3:0] ADDR_P10_ALT  = 4'h8;
  localparam logic [7:0] PORT_RESET     = 8'h00;
  localparam logic [7:0] P8_IMPL_MASK   = 8'hdf;
  localparam logic [7:0] P9_IMPL_MASK   = 8'h8f;
  localparam logic [7:0] P10_IMPL_MASK  = 8'hbf;
  localparam logic [7:0] P8_FIXED_LOW   = 8'h01;
  localparam logic [7:0] P9_FIXED_LOW   = 8'h0f;
  localparam logic [7:0] P10_FIXED_LOW  = 8'hba;
endpackage

// ===== hw/gpio_port_bank.sv
// one 8-bit port: data, direction and alternate-select registers with pin logic
// assumes pins already synchronised and peripheral outputs on sys_clk_i
`timescale 1ns/100ps
module gpio_port_bank
  import gpio_ports_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = 8'hff,
  parameter logic [7:0] FIXED_LOW = 8'h00
) (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       wr_data_i,
  input  wire logic       wr_dir_i,
  input  wire logic       wr_alt_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] pin_sync_i,
  input  wire logic [7:0] alt_out_i,
  input  wire logic [7:0] alt_read_i,
  output logic      [7:0] data_q_o,
  output logic      [7:0] dir_q_o,
  output logic      [7:0] alt_q_o,
  output logic      [7:0] read_o,
  output logic      [7:0] pin_o_d,
  output logic      [7:0] pin_oe_d,
  output logic      [7:0] pull_d
);
  logic [7:0] sec_out;
  logic [7:0] alt_val;
  assign sec_out = dir_q_o & alt_q_o;
  assign alt_val = alt_out_i & ~FIXED_LOW;
  // read selection per bit, also used for read-modify-write source
  assign read_o = IMPL_MASK & ((~dir_q_o & pin_sync_i)
                | (dir_q_o & ~alt_q_o & data_q_o)
                | (sec_out & alt_read_i));
  assign pin_oe_d = IMPL_MASK & dir_q_o;
  assign pin_o_d  = IMPL_MASK & ((dir_q_o & ~alt_q_o & data_q_o) | (sec_out & alt_val));
  assign pull_d   = IMPL_MASK & ~dir_q_o & alt_q_o;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      data_q_o <= PORT_RESET;
      dir_q_o  <= PORT_RESET;
      alt_q_o  <= PORT_RESET;
    end else begin
      if (wr_data_i) data_q_o <= wdata_i & IMPL_MASK;
      if (wr_dir_i)  dir_q_o  <= wdata_i & IMPL_MASK;
      if (wr_alt_i)  alt_q_o  <= wdata_i & IMPL_MASK;
    end
  end

  fixed_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (pin_o_d & sec_out & FIXED_LOW) == 8'h00) else $error("fixed-low pin driven high");
endmodule // gpio_port_bank

// ===== dv/gpio_pin_pad.sv
// pad model for one 8-bit port: driven, pulled up or left to an outside level
// assumes ext_i is what an outside source puts on a pin nobody drives
`timescale 1ns/100ps
module gpio_pin_pad (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pull_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] lvl_o
);
  assign lvl_o = (oe_i & drv_i) | (~oe_i & pull_i) | (~oe_i & ~pull_i & ext_i);
endmodule // gpio_pin_pad

// ===== dv/tb_gpio_ports_8_to_10.sv
// self-checking bench: random port setups against a register and pin model
// assumes the pad model in gpio_pin_pad.sv
`timescale 1ns/100ps
module tb_gpio_ports_8_to_10
  import gpio_ports_pkg::*;
;
  logic       clk = 0, srst = 1, wr = 0, rd = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [8:0] per_q = 9'h000;
  logic [7:0] ext[3], dat[3], dir[3], alt[3];
  wire  [7:0] po[3], poe[3], ppl[3], pin[3];
  wire  [7:0] pio;
  int         n_errors = 0, n_tests = 0;
  always #10 clk = ~clk;
  gpio_ports_8_to_10 dut_u (
    .sys_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata),
    .p8_pin_i(pin[0]), .p8_pin_o(po[0]), .p8_pin_oe_o(poe[0]), .p8_pull_o(ppl[0]),
    .p9_pin_i(pin[1]), .p9_pin_o(po[1]), .p9_pin_oe_o(poe[1]), .p9_pull_o(ppl[1]),
    .p10_pin_i(pin[2]), .p10_pin_o(po[2]), .p10_pin_oe_o(poe[2]), .p10_pull_o(ppl[2]),
    .serial1_transmit_data_i(per_q[0]), .serial1_receive_clock_i(per_q[1]),
    .serial1_transmit_clock_i(per_q[2]), .timer_four_output_i(per_q[3]),
    .pwm_channel_two_output_i(per_q[4]), .pwm_channel_three_output_i(per_q[5]),
    .bus_hold_acknowledge_i(per_q[6]), .serial3_clock_i(per_q[7]),
    .serial3_data_out_i(per_q[8]),
    .serial1_receive_data_o(pio[0]), .serial1_receive_clock_o(pio[1]),
    .serial1_transmit_clock_o(pio[2]), .external_irq_four_o(pio[3]),
    .external_irq_five_o(pio[4]), .serial3_clock_o(pio[5]), .serial3_data_in_o(pio[6]),
    .timer_five_event_input_o(pio[7])
  );
  for (genvar g = 0; g < 3; g++) begin : g_pad
    gpio_pin_pad pad_u (.drv_i(po[g]), .oe_i(poe[g]), .pull_i(ppl[g]), .ext_i(ext[g]),
                        .lvl_o(pin[g]));
  end
  function automatic logic [7:0] im(int p);
    return (p == 0) ? P8_IMPL_MASK : (p == 1) ? P9_IMPL_MASK : P10_IMPL_MASK;
  endfunction
  function automatic logic [7:0] fx(int p);
    return (p == 0) ? P8_FIXED_LOW : (p == 1) ? P9_FIXED_LOW : P10_FIXED_LOW;
  endfunction
  function automatic logic [7:0] per(int p);
    if (p == 0) return {per_q[5], per_q[4], 1'b0, per_q[3:0], 1'b0};
    if (p == 1) return {per_q[6], 7'h00};
    return {5'h00, per_q[8], 1'b0, per_q[7]};
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input int a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= 4'(a);
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input int a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= 4'(a);
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      dat[p] = 8'h00;
      dir[p] = 8'h00;
      alt[p] = 8'h00;
    end
  endtask
  task automatic check_port(input int p);
    logic [7:0] v, oe, o, pl, lv, rd_exp;
    repeat (6) @(posedge clk);
    oe = im(p) & dir[p];
    o = (dir[p] & ~alt[p] & dat[p]) | (dir[p] & alt[p] & ~fx(p) & per(p));
    pl = im(p) & ~dir[p] & alt[p];
    lv = (oe & o) | (~oe & pl) | (~oe & ~pl & ext[p]);
    rd_exp = (~dir[p] & lv) | (dir[p] & ~alt[p] & dat[p]);
    rd_exp = im(p) & (rd_exp | (dir[p] & alt[p] & per(p)));
    cmp(poe[p], oe);
    cmp(po[p] & oe, o & oe);
    cmp(ppl[p], pl);
    if (p == 0) cmp({5'h00, pio[2:0]}, {5'h00, lv[3:2], lv[0]});
    if (p == 1) cmp({6'h00, pio[4:3]}, {6'h00, lv[1:0]});
    if (p == 2) cmp({5'h00, pio[7:5]}, {5'h00, lv[7], lv[1:0]});
    bus_rd(3 * p, v);
    cmp(v, rd_exp);
    bus_rd(3 * p + 1, v);
    cmp(v, dir[p]);
    bus_rd(3 * p + 2, v);
    cmp(v, alt[p]);
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    int p;
    logic [7:0] v, x;
    for (int i = 0; i < 3; i++) ext[i] = 8'h00;
    void'($urandom(3));
    do_reset();
    for (int i = 0; i < 3; i++) check_port(i);
    for (int n = 0; n < 80; n++) begin
      p = $urandom_range(2);
      x = 8'($urandom);
      bus_wr(3 * p + 1, x);
      dir[p] = x & im(p);
      x = 8'($urandom);
      bus_wr(3 * p + 2, x);
      alt[p] = x & im(p);
      ext[p] <= 8'($urandom);
      per_q <= 9'($urandom);
      check_port(p);
      bus_rd(3 * p, v);
      x = v ^ 8'($urandom);
      bus_wr(3 * p, x);
      dat[p] = x & im(p);
      check_port(p);
      bus_wr($urandom_range(15, 9), 8'($urandom));
      bus_rd($urandom_range(15, 9), v);
      cmp(v, 8'h00);
      if (n % 20 == 19) begin
        do_reset();
        check_port(p);
      end
    end
    print_verdict();
  end
endmodule // tb_gpio_ports_8_to_10
